// ### uhi_device.sv
// Interrupt status, enable and disable registers with event detection and request output.
//
// Decided for this implementation: strobed register access.
module uhi_device
	import uhi_pkg::*;
#(
	parameter int PORTS = 2,
	parameter int PORT_W = 32
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Command link.
	uhi_link_if.device link,
	// Root hub and frame counter state.
	input wire logic [31:0] root_hub_state_reg,
	input wire logic [PORTS*PORT_W-1:0] port_state_reg,
	input wire logic [15:0] frame_count_reg,
	// Event strobes from the controller core, the resume line from the bus and the functional state level.
	input wire logic system_error,
	input wire logic error_corrected,
	input wire logic soft_reset,
	input wire logic frame_start,
	input wire logic frame_overrun,
	input wire logic resume_pin,
	input wire logic resume_functional_state,
	// Core controls and visible state.
	output logic sof_token,
	output logic processing_halt,
	output logic [1:0] overrun_counter
);
	typedef struct packed {
		logic [31:0] flags;
		logic [31:0] enable;
		logic [1:0] overruns;
		logic halt;
		logic sof;
		logic irq;
		logic rsp_valid;
		logic [31:0] rsp_rdata;
		logic resume_meta;
		logic resume_sync;
		logic resume_prev;
		logic frame_msb_prev;
		logic [31:0] hub_prev;
		logic [PORTS*PORT_W-1:0] port_prev;
		logic primed;
	} uhi_dev_state_t;

	uhi_dev_state_t st;
	uhi_dev_state_t next_st;

	always_comb begin
		logic [31:0] set_bits;
		logic [31:0] clr_bits;
		logic wr;
		set_bits = 32'h0;
		clr_bits = 32'h0;
		wr = link.cmd_valid;
		next_st = st;

		// Two-flop synchroniser for the resume line from the bus.
		next_st.resume_meta = resume_pin;
		next_st.resume_sync = st.resume_meta;
		next_st.resume_prev = st.resume_sync;
		next_st.frame_msb_prev = frame_count_reg[15];
		next_st.hub_prev = root_hub_state_reg;
		next_st.port_prev = port_state_reg;
		// Change detection needs one sampled value before it can compare.
		next_st.primed = 1'b1;

		if (st.primed && (root_hub_state_reg != st.hub_prev || port_state_reg != st.port_prev)) begin
			set_bits[BIT_ROOT_HUB] = 1'b1; // RL1
		end
		if (st.primed && frame_count_reg[15] != st.frame_msb_prev) begin
			set_bits[BIT_FRAME_OVERFLOW] = 1'b1; // RL2
		end
		if (system_error) begin
			set_bits[BIT_UNRECOVERABLE] = 1'b1; // RL3
		end
		// The functional state input is deliberately not an event source.
		if (st.resume_sync && !st.resume_prev && !resume_functional_state) begin
			set_bits[BIT_RESUME] = 1'b1; // RL6 RL7
		end
		if (resume_functional_state && st.resume_sync && !st.resume_prev) begin
			set_bits[BIT_RESUME] = 1'b1; // RL6
		end
		next_st.sof = frame_start && !st.halt; // RL8
		if (frame_start && !st.halt) begin
			set_bits[BIT_SOF] = 1'b1; // RL8
		end
		if (frame_overrun && !st.halt) begin
			set_bits[BIT_OVERRUN] = 1'b1; // RL9
			next_st.overruns = st.overruns + 2'h1; // RL10 RL22
		end

		// Halt stays until the core reports the error corrected or a reset.
		if (system_error) begin
			next_st.halt = 1'b1; // RL4
		end else if (error_corrected || soft_reset) begin
			next_st.halt = 1'b0; // RL4 RL5
		end

		next_st.rsp_valid = 1'b0;
		next_st.rsp_rdata = 32'h0;
		if (wr) begin
			case (link.cmd_code)
				CMD_STATUS_WR: begin
					clr_bits = link.cmd_wdata & EVENT_MASK; // RL18 RL21 RL23
				end
				CMD_ENABLE_WR: begin
					next_st.enable = st.enable | (link.cmd_wdata & ENABLE_MASK); // RL13 RL15 RL19 RL23
				end
				CMD_DISABLE_WR: begin
					next_st.enable = st.enable & ~(link.cmd_wdata & ENABLE_MASK); // RL16 RL20
				end
				CMD_STATUS_RD: begin
					next_st.rsp_valid = 1'b1;
					next_st.rsp_rdata = st.flags & EVENT_MASK; // RL18 RL23
				end
				CMD_ENABLE_RD: begin
					next_st.rsp_valid = 1'b1;
					next_st.rsp_rdata = st.enable & ENABLE_MASK; // RL14 RL19
				end
				CMD_DISABLE_RD: begin
					next_st.rsp_valid = 1'b1;
					next_st.rsp_rdata = st.enable & ENABLE_MASK; // RL17 RL20
				end
				default: begin
					next_st.rsp_valid = is_read_code(link.cmd_code);
				end
			endcase
		end

		// A set arriving with its clear wins.
		next_st.flags = ((st.flags & ~clr_bits) | set_bits) & EVENT_MASK; // RL21

		// Soft reset returns the registers to their reset values.
		if (soft_reset) begin
			next_st.flags = FLAGS_RESET;
			next_st.enable = ENABLE_RESET;
			next_st.overruns = OVERRUN_RESET;
		end

		next_st.irq = st.enable[BIT_MASTER] && |(st.flags & st.enable & EVENT_MASK); // RL11 RL12 RL24
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign link.rsp_valid = st.rsp_valid;
	assign link.rsp_rdata = st.rsp_rdata;
	assign link.irq = st.irq;
	assign sof_token = st.sof;
	assign processing_halt = st.halt;
	assign overrun_counter = st.overruns;
endmodule : uhi_device

// ### uhi_pkg.sv
// Shared constants and types for the interrupt status and enable logic and its controller.
// Operation
// RL1 - Root hub or port change sets bit 6
// RL2 - Frame counter bit 15 toggle sets bit 5
// RL3 - Non-USB system error sets bit 4
// RL4 - After system error, halt lists and signaling
// RL5 - Driver clears error flag only after reset
// RL6 - Resume start after idle sets bit 3
// RL7 - Entering resume state never sets bit 3
// RL8 - Each frame start emits SOF, sets bit 2; the code does neither while halted
// RL9 - Unfinished frame work sets bit 0; the code sets it only while not halted
// RL10 - Each overrun increments counter regardless of flag; the code counts only while not halted
// RL11 - Request when flag, enable and master set
// RL12 - Enable bits mirror status bit positions
// RL13 - Enable write sets ones, ignores zeros
// RL14 - Enable read returns mask with master bit
// RL15 - Master bit 31 set by one only
// RL16 - Disable write clears ones, master included
// RL17 - Disable read returns enable mask
// RL18 - Status: read code 03, write 83
// RL19 - Enable: read code 04, write 84
// RL20 - Disable: read code 05, write 85
// RL21 - Status flags write-one-to-clear, hardware sets only
// RL22 - Overrun counter starts 00, wraps after 11
// RL23 - Reserved bits read zero, writes ignored
// RL24 - Request is level, drops one clock later
package uhi_pkg;
	localparam logic [7:0] CMD_STATUS_RD = 8'h03;
	localparam logic [7:0] CMD_STATUS_WR = 8'h83;
	localparam logic [7:0] CMD_ENABLE_RD = 8'h04;
	localparam logic [7:0] CMD_ENABLE_WR = 8'h84;
	localparam logic [7:0] CMD_DISABLE_RD = 8'h05;
	localparam logic [7:0] CMD_DISABLE_WR = 8'h85;
	localparam int BIT_OVERRUN = 0;
	localparam int BIT_SOF = 2;
	localparam int BIT_RESUME = 3;
	localparam int BIT_UNRECOVERABLE = 4;
	localparam int BIT_FRAME_OVERFLOW = 5;
	localparam int BIT_ROOT_HUB = 6;
	localparam int BIT_MASTER = 31;
	localparam logic [31:0] EVENT_MASK = 32'h0000_007d;
	localparam logic [31:0] ENABLE_MASK = 32'h8000_007d;
	localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
	localparam logic [1:0] OVERRUN_RESET = 2'h0;
	// Controller register map on the software port.
	localparam logic [1:0] CTL_ADDR_COMMAND = 2'h0;
	localparam logic [1:0] CTL_ADDR_DATA = 2'h1;
	localparam logic [1:0] CTL_ADDR_STATUS = 2'h2;
	localparam int CTL_STAT_BUSY = 0;
	localparam int CTL_STAT_IRQ = 1;
	localparam int CTL_STAT_DONE = 2;

	typedef enum logic [1:0] {
		UHC_IDLE = 2'b00,
		UHC_ISSUE = 2'b01,
		UHC_WAIT = 2'b11
	} uhi_ctl_state_t;

	function automatic logic is_read_code(input logic [7:0] code);
		return code == CMD_STATUS_RD || code == CMD_ENABLE_RD || code == CMD_DISABLE_RD;
	endfunction : is_read_code
endpackage : uhi_pkg

// ### uhi_link_if.sv
// Command link between the interrupt logic and the controller that drives it.
interface uhi_link_if;
	logic cmd_valid;
	logic [7:0] cmd_code;
	logic [31:0] cmd_wdata;
	logic rsp_valid;
	logic [31:0] rsp_rdata;
	logic irq;

	modport device (
		input cmd_valid,
		input cmd_code,
		input cmd_wdata,
		output rsp_valid,
		output rsp_rdata,
		output irq
	);

	modport host (
		output cmd_valid,
		output cmd_code,
		output cmd_wdata,
		input rsp_valid,
		input rsp_rdata,
		input irq
	);
endinterface : uhi_link_if

// ### uhi_host.sv
// Controller that turns software port accesses into commands on the interrupt link.
module uhi_host
	import uhi_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Software port.
	input wire logic [1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Interrupt request seen by software.
	output logic irq_out,
	// Command link.
	uhi_link_if.host link
);
	typedef struct packed {
		uhi_ctl_state_t fsm;
		logic [7:0] code;
		logic [31:0] data;
		logic done;
		logic irq;
		logic cmd_valid;
		logic [31:0] rdata;
	} uhi_host_state_t;

	uhi_host_state_t st;
	uhi_host_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.cmd_valid = 1'b0;
		next_st.rdata = 32'h0;
		next_st.irq = link.irq;

		if (rd) begin
			case (addr)
				CTL_ADDR_COMMAND: next_st.rdata = {24'h0, st.code};
				CTL_ADDR_DATA: next_st.rdata = st.data;
				CTL_ADDR_STATUS: begin
					next_st.rdata[CTL_STAT_BUSY] = st.fsm != UHC_IDLE;
					next_st.rdata[CTL_STAT_IRQ] = st.irq;
					next_st.rdata[CTL_STAT_DONE] = st.done;
				end
				default: next_st.rdata = 32'h0;
			endcase
		end

		case (st.fsm)
			UHC_IDLE: begin
				if (wr && addr == CTL_ADDR_DATA) begin
					next_st.data = wdata;
				end
				if (wr && addr == CTL_ADDR_COMMAND) begin
					next_st.code = wdata[7:0];
					next_st.done = 1'b0;
					next_st.cmd_valid = 1'b1;
					next_st.fsm = UHC_ISSUE;
				end
			end
			UHC_ISSUE: begin
				// Only the six documented codes are issued usefully; reads wait for an answer.
				if (is_read_code(st.code)) begin
					next_st.fsm = UHC_WAIT; // RL18 RL19 RL20
				end else begin
					next_st.done = 1'b1;
					next_st.fsm = UHC_IDLE;
				end
			end
			UHC_WAIT: begin
				if (link.rsp_valid) begin
					next_st.data = link.rsp_rdata;
					next_st.done = 1'b1;
					next_st.fsm = UHC_IDLE;
				end
			end
			default: next_st.fsm = UHC_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign link.cmd_valid = st.cmd_valid;
	assign link.cmd_code = st.code;
	assign link.cmd_wdata = st.data;
	assign rdata = st.rdata;
	assign irq_out = st.irq;
endmodule : uhi_host

// ### uhi_link_props.sv
// Checker for the command link between the controller and the interrupt logic.
module uhi_link_props
	import uhi_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Link.
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [31:0] cmd_wdata,
	input wire logic rsp_valid,
	input wire logic [31:0] rsp_rdata,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic master_irq_enable;
	logic rd_cmd;
	assign rd_cmd = cmd_valid && (cmd_code == CMD_STATUS_RD || cmd_code == CMD_ENABLE_RD || cmd_code == CMD_DISABLE_RD);
	// Follows the master enable as the link commands set and clear it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			master_irq_enable <= 1'b0;
		end else if (cmd_valid && cmd_wdata[BIT_MASTER] && cmd_code == CMD_ENABLE_WR) begin
			master_irq_enable <= 1'b1;
		end else if (cmd_valid && cmd_wdata[BIT_MASTER] && cmd_code == CMD_DISABLE_WR) begin
			master_irq_enable <= 1'b0;
		end
	end
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_answer; rd_cmd |=> rsp_valid; endproperty
	a_answer: assert property (p_answer) else $error("read without answer");
	property p_quiet; cmd_valid && cmd_code[7] |=> !rsp_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("write answered");
	property p_cause; rsp_valid |-> $past(rd_cmd); endproperty
	a_cause: assert property (p_cause) else $error("answer without read");
	property p_flags; cmd_valid && cmd_code == CMD_STATUS_RD |=> (rsp_rdata & ~EVENT_MASK) == 32'h0; endproperty
	a_flags: assert property (p_flags) else $error("flag reserved bit set");
	property p_mask; rd_cmd && cmd_code != CMD_STATUS_RD |=> (rsp_rdata & ~ENABLE_MASK) == 32'h0; endproperty
	a_mask: assert property (p_mask) else $error("enable reserved bit set");
	property p_off; cmd_valid && cmd_code == CMD_DISABLE_WR && cmd_wdata[BIT_MASTER] |=> ##1 !irq; endproperty
	a_off: assert property (p_off) else $error("request after master clear");
	property p_irq; irq |-> $past(master_irq_enable); endproperty
	a_irq: assert property (p_irq) else $error("request without master");
	property p_mie; cmd_valid && cmd_code == CMD_ENABLE_RD |=> rsp_rdata[BIT_MASTER] == $past(master_irq_enable); endproperty
	a_mie: assert property (p_mie) else $error("master bit misread");
	c_set: cover property (cmd_valid && cmd_code == CMD_ENABLE_WR);
	c_flag: cover property (rsp_valid && rsp_rdata != 32'h0);
	c_irq: cover property ($rose(irq));
endmodule : uhi_link_props

// ### uhi_bench.sv
// Testbench joining the controller and the interrupt logic over the link.
module uhi_bench;
	import uhi_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic irq_out;
	logic [31:0] hub = 32'h0;
	logic [63:0] port = 64'h0;
	logic [15:0] frame = 16'h0;
	logic [4:0] ev = 5'h0;
	logic res_pin = 1'b0;
	logic res_st = 1'b0;
	logic sof_token;
	logic halt;
	logic [1:0] cnt;
	logic [31:0] r;
	int fails = 0;
	int comparisons = 0;
	int sofs = 0;
	uhi_link_if link();
	uhi_device uhi_device_i(.clk(clk), .rst(rst), .link(link), .root_hub_state_reg(hub), .port_state_reg(port),
		.frame_count_reg(frame), .system_error(ev[0]), .error_corrected(ev[1]), .soft_reset(ev[2]),
		.frame_start(ev[3]), .frame_overrun(ev[4]), .resume_pin(res_pin), .resume_functional_state(res_st),
		.sof_token(sof_token), .processing_halt(halt), .overrun_counter(cnt));
	uhi_host uhi_host_i(.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.irq_out(irq_out), .link(link));
	uhi_link_props uhi_link_props_i(.clk(clk), .rst(rst), .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
		.cmd_wdata(link.cmd_wdata), .rsp_valid(link.rsp_valid), .rsp_rdata(link.rsp_rdata), .irq(link.irq));
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (sof_token === 1'b1) sofs++;
	end
	task automatic conclude;
		if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic put(input logic [1:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : put
	task automatic get(input logic [1:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : get
	// Issues one link command and leaves the data register in r: the answer after a read, the written data after a write.
	task automatic cmd(input logic [7:0] c, input logic [31:0] d);
		logic [31:0] s;
		put(CTL_ADDR_DATA, d);
		put(CTL_ADDR_COMMAND, {24'h0, c});
		for (int i = 0; i < 20; i++) begin
			get(CTL_ADDR_STATUS, s);
			if (s[CTL_STAT_BUSY] === 1'b0) break;
			if (i == 19) begin
				fails++;
				conclude();
			end
		end
		get(CTL_ADDR_DATA, r);
	endtask : cmd
	task automatic pulse(input int b);
		@(posedge clk);
		ev[b] <= 1'b1;
		@(posedge clk);
		ev[b] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : pulse
	task automatic see_irq(input logic v);
		// Look a moment after each edge so the registered request has settled.
		for (int i = 0; i < 8 && irq_out !== v; i++) begin
			@(posedge clk);
			#1;
		end
		check({31'h0, irq_out}, {31'h0, v}, "irq_out");
	endtask : see_irq
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		cmd(CMD_STATUS_RD, 32'h0);
		check(r, FLAGS_RESET, "flags");
		cmd(CMD_ENABLE_WR, 32'hffff_ffff);
		cmd(CMD_ENABLE_RD, 32'h0);
		check(r, ENABLE_MASK, "enable");
		cmd(CMD_DISABLE_RD, 32'h0);
		check(r, ENABLE_MASK, "disable");
		cmd(CMD_DISABLE_WR, 32'h8000_0004);
		cmd(CMD_ENABLE_WR, 32'h0);
		cmd(CMD_DISABLE_RD, 32'h0);
		check(r, 32'h0000_0079, "disable");
		pulse(3);
		check(sofs, 1, "sofs");
		pulse(4);
		pulse(4);
		check({30'h0, cnt}, 32'h2, "count");
		@(posedge clk);
		frame <= 16'h8000;
		hub <= 32'h1;
		res_st <= 1'b1;
		cmd(CMD_STATUS_RD, 32'h0);
		check(r, 32'h0000_0065, "flags");
		cmd(CMD_STATUS_WR, 32'hffff_ffff);
		cmd(CMD_STATUS_RD, 32'h0);
		check(r, 32'h0, "flags");
		@(posedge clk);
		port[40] <= 1'b1;
		res_pin <= 1'b1;
		pulse(0);
		check({31'h0, halt}, 32'h1, "halt");
		pulse(3);
		check(sofs, 1, "sofs");
		pulse(1);
		check({31'h0, halt}, 32'h0, "halt");
		cmd(CMD_STATUS_RD, 32'h0);
		check(r, 32'h0000_0058, "flags");
		see_irq(1'b0);
		cmd(CMD_ENABLE_WR, 32'h8000_0000);
		see_irq(1'b1);
		cmd(CMD_DISABLE_WR, 32'h8000_0000);
		see_irq(1'b0);
		cmd(CMD_ENABLE_WR, 32'h8000_0000);
		see_irq(1'b1);
		// The driver leaves the error flag set until the controller is reset, so only its enable is dropped here.
		cmd(CMD_DISABLE_WR, 32'h0000_0010);
		cmd(CMD_STATUS_WR, 32'h0000_006d);
		see_irq(1'b0);
		pulse(4);
		pulse(4);
		check({30'h0, cnt}, 32'h0, "count");
		pulse(2);
		cmd(CMD_DISABLE_WR, 32'h8000_0000);
		cmd(CMD_ENABLE_WR, 32'h7fff_ff82);
		cmd(CMD_ENABLE_RD, 32'h0);
		check(r, 32'h0, "enable");
		conclude();
	end
endmodule : uhi_bench
